// ---- rtl/hciut_top.sv ----
// Host-interface UART transport with APB registers
`timescale 1ns/1ps
module hciut_top
	import hciut_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// UART pins
	input  wire logic        rxd,
	output logic             txd,
	output logic             host_flow_stop_out,
	input  wire logic        device_flow_stop_in
);

	// Control and status state
	logic [15:0]      baud_div;
	logic [15:0]      baud_pend;
	logic             baud_pend_vld;
	logic             par_en;
	logic             par_odd;
	logic             pkt_open;
	logic             sleep_req;
	logic [3:0]       rx_thresh;
	logic [ERR_N-1:0] err_flags;
	logic [ERR_N-1:0] err_set;
	logic [ERR_N-1:0] err_clr;
	hciut_mode_t      mode;
	hciut_mode_t      next_mode;
	logic             tx_paused;
	logic             cts_q;
	logic             asleep;

	// Bus
	logic             acc;
	logic             wr_done;
	logic             rd_done;
	logic [31:0]      next_prdata;
	logic             next_slverr;

	// FIFOs
	logic             tx_in_valid;
	logic             tx_in_ready;
	logic             tx_out_valid;
	logic             tx_out_ready;
	logic [7:0]       tx_out_data;
	logic [3:0]       tx_level;
	logic             rx_in_valid;
	logic             rx_in_ready;
	logic             rx_out_valid;
	logic             rx_out_ready;
	logic [7:0]       rx_out_data;
	logic [3:0]       rx_level;

	// Transmitter
	logic             tx_busy;
	logic [9:0]       tx_shift;
	logic [3:0]       tx_left;
	logic [15:0]      tx_cnt;
	logic             tx_start;
	logic             tx_end;
	logic             flow_stop;

	// Receiver
	hciut_rx_t        rx_state;
	logic [15:0]      rx_cnt;
	logic [7:0]       rx_sh;
	logic [2:0]       rx_n;
	logic             rx_perr;
	logic             rx_got;
	logic             rx_drop;
	logic [15:0]      idle_cyc;
	logic [3:0]       idle_bits;
	logic             idle_arm;
	logic [15:0]      crc_run;
	logic [15:0]      crc_last;
	logic             crc_any;

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// APB slave: one wait state, pready stalls a TXDATA write while the TX FIFO is full
	assign acc     = psel & penable;
	assign wr_done = acc & pready & pwrite;
	assign rd_done = acc & pready & ~pwrite;

	always_comb begin
		next_prdata = 32'h0;
		next_slverr = 1'b0;
		if (paddr == OFS_CTRL) begin
			next_prdata = {28'h0, sleep_req, pkt_open, par_odd, par_en};
		end else if (paddr == OFS_BAUD) begin
			next_prdata = {16'h0, baud_div};
		end else if (paddr == OFS_TXDATA) begin
			next_prdata = 32'h0;
		end else if (paddr == OFS_RXDATA) begin
			next_prdata = rx_out_valid ? {24'h0, rx_out_data} : 32'h0;
		end else if (paddr == OFS_STATUS) begin
			next_prdata = {19'h0, asleep, baud_pend_vld, tx_paused, mode, 1'b0, err_flags};
		end else if (paddr == OFS_LEVEL) begin
			next_prdata = {20'h0, tx_level, 4'h0, rx_level};
		end else if (paddr == OFS_THRESH) begin
			next_prdata = {28'h0, rx_thresh};
		end else if (paddr == OFS_CRC) begin
			next_prdata = {16'h0, crc_last};
		end else begin
			next_slverr = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (pready) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (acc && !(pwrite && paddr == OFS_TXDATA && !tx_in_ready)) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0 : next_prdata;
			pslverr <= next_slverr;
		end
	end

	// Software-written control
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			par_en    <= 1'b0;
			par_odd   <= 1'b0;
			pkt_open  <= 1'b0;
			sleep_req <= 1'b0;
			rx_thresh <= THRESH_RST;
		end else if (wr_done && paddr == OFS_CTRL) begin
			par_en    <= pwdata[CTRL_PAR_EN];
			par_odd   <= pwdata[CTRL_PAR_ODD];
			pkt_open  <= pwdata[CTRL_PKT];
			sleep_req <= pwdata[CTRL_SLEEP];
		end else if (wr_done && paddr == OFS_THRESH) begin
			rx_thresh <= pwdata[3:0];
		end
	end

	// New rate is held until every queued byte, the byte being shifted out among them, has left
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			baud_div      <= DIV_BOOT;
			baud_pend     <= DIV_BOOT;
			baud_pend_vld <= 1'b0;
		end else if (wr_done && paddr == OFS_BAUD) begin
			baud_pend     <= (pwdata[15:0] < DIV_MIN) ? DIV_MIN : pwdata[15:0];
			baud_pend_vld <= 1'b1;
		end else if (baud_pend_vld && !tx_busy && !tx_out_valid) begin
			baud_div      <= baud_pend;
			baud_pend_vld <= 1'b0;
		end
	end

	// Sticky flags, write one to clear; a new event wins over the clear
	assign err_clr = (wr_done && paddr == OFS_STATUS) ? pwdata[ERR_N-1:0] : '0;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			err_flags <= '0;
		end else begin
			err_flags <= (err_flags & ~err_clr) | err_set;
		end
	end

	// TX FIFO filled from the bus, drained by the transmitter
	assign tx_in_valid = wr_done && paddr == OFS_TXDATA;

	hciut_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clock     (clock),
		.rstn      (rstn),
		.in_valid  (tx_in_valid),
		.in_ready  (tx_in_ready),
		.in_data   (pwdata[7:0]),
		.out_valid (tx_out_valid),
		.out_ready (tx_out_ready),
		.out_data  (tx_out_data),
		.level     (tx_level)
	);

	// RX FIFO filled by the receiver, drained by bus reads
	assign rx_out_ready = rd_done && paddr == OFS_RXDATA;

	hciut_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clock     (clock),
		.rstn      (rstn),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.in_data   (rx_sh),
		.out_valid (rx_out_valid),
		.out_ready (rx_out_ready),
		.out_data  (rx_out_data),
		.level     (rx_level)
	);

	// Flow control: CTS in four-wire mode, XON/XOFF in three-wire mode
	assign asleep    = sleep_req && mode != hciut_mode_h5 && !tx_busy;
	assign flow_stop = (mode == hciut_mode_h5) ? tx_paused : device_flow_stop_in;
	// Checked only between bytes, so a byte in flight always finishes
	assign tx_start     = !tx_busy && tx_out_valid && !flow_stop && !asleep;
	assign tx_out_ready = tx_start;
	assign tx_end       = tx_busy && tx_cnt == 16'h0 && tx_left == 4'h0;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			txd      <= 1'b1;
			tx_busy  <= 1'b0;
			tx_shift <= '1;
			tx_left  <= 4'h0;
			tx_cnt   <= 16'h0;
		end else if (tx_start) begin
			txd      <= 1'b0;
			tx_busy  <= 1'b1;
			tx_shift <= {1'b1, par_en ? (^tx_out_data ^ par_odd) : 1'b1, tx_out_data};
			tx_left  <= par_en ? 4'ha : 4'h9;
			tx_cnt   <= baud_div - 16'h1;
		end else if (tx_busy) begin
			if (tx_cnt != 16'h0) begin
				tx_cnt <= tx_cnt - 16'h1;
			end else if (tx_left == 4'h0) begin
				tx_busy <= 1'b0;
			end else begin
				txd      <= tx_shift[0];
				tx_shift <= {1'b1, tx_shift[9:1]};
				tx_left  <= tx_left - 4'h1;
				tx_cnt   <= baud_div - 16'h1;
			end
		end
	end

	// Receiver: sample mid-bit, start bit rechecked to reject glitches
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_state <= rx_idle;
			rx_cnt   <= 16'h0;
			rx_sh    <= 8'h0;
			rx_n     <= 3'h0;
			rx_perr  <= 1'b0;
			rx_got   <= 1'b0;
		end else begin
			rx_got <= 1'b0;
			case (rx_state)
				rx_idle: begin
					if (!rxd) begin
						rx_state <= rx_start;
						rx_cnt   <= baud_div >> 1;
					end
				end
				rx_start: begin
					if (rx_cnt != 16'h0) begin
						rx_cnt <= rx_cnt - 16'h1;
					end else if (rxd) begin
						rx_state <= rx_idle;
					end else begin
						rx_state <= rx_data;
						rx_cnt   <= baud_div - 16'h1;
						rx_n     <= 3'h0;
						rx_perr  <= 1'b0;
					end
				end
				rx_data: begin
					if (rx_cnt != 16'h0) begin
						rx_cnt <= rx_cnt - 16'h1;
					end else begin
						rx_sh  <= {rxd, rx_sh[7:1]};
						rx_n   <= rx_n + 3'h1;
						rx_cnt <= baud_div - 16'h1;
						if (rx_n == 3'h7) begin
							rx_state <= par_en ? rx_par : rx_stop;
						end
					end
				end
				rx_par: begin
					if (rx_cnt != 16'h0) begin
						rx_cnt <= rx_cnt - 16'h1;
					end else begin
						rx_perr  <= rxd ^ (^rx_sh) ^ par_odd;
						rx_state <= rx_stop;
						rx_cnt   <= baud_div - 16'h1;
					end
				end
				rx_stop: begin
					if (rx_cnt != 16'h0) begin
						rx_cnt <= rx_cnt - 16'h1;
					end else begin
						rx_got   <= 1'b1;
						rx_state <= rxd ? rx_idle : rx_hold;
					end
				end
				rx_hold: begin
					// A low line after a bad stop must rise before a new start counts
					if (rxd) begin
						rx_state <= rx_idle;
					end
				end
				default: rx_state <= rx_idle;
			endcase
		end
	end

	// Byte handling; a byte with a bad stop bit is dropped
	always_comb begin
		next_mode = mode;
		if (mode == hciut_mode_unknown) begin
			next_mode = (rx_sh == BYTE_SLIP) ? hciut_mode_h5 : hciut_mode_h4;
		end
	end

	assign rx_drop = next_mode == hciut_mode_h5 && (rx_sh == BYTE_XON || rx_sh == BYTE_XOFF);
	// Link messages, power messages among them, pass unchanged to software, except XON and XOFF, which three-wire mode drops
	assign rx_in_valid = rx_got && rx_state == rx_idle && !rx_drop;

	always_comb begin
		err_set            = '0;
		err_set[ERR_BREAK] = rx_got && rx_state == rx_hold && rx_sh == 8'h0;
		err_set[ERR_FRAME] = rx_got && rx_state == rx_hold && rx_sh != 8'h0;
		err_set[ERR_PAR]   = rx_got && rx_perr;
		err_set[ERR_OVFL]  = rx_in_valid && !rx_in_ready;
		err_set[ERR_IDLE]  = idle_arm && idle_bits == IDLE_BITS;
		err_set[ERR_UNDER] = tx_end && pkt_open && !tx_out_valid;
		err_set[ERR_WAKE]  = asleep && cts_q && !device_flow_stop_in;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode      <= hciut_mode_unknown;
			tx_paused <= 1'b0;
		end else if (rx_got && rx_state == rx_idle) begin
			mode <= next_mode;
			if (next_mode == hciut_mode_h5 && rx_sh == BYTE_XOFF) begin
				tx_paused <= 1'b1;
			end else if (next_mode == hciut_mode_h5 && rx_sh == BYTE_XON) begin
				tx_paused <= 1'b0;
			end
		end
	end

	// Packet CRC over bytes between frame delimiters, latched at each closing delimiter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			crc_run  <= CRC_INIT;
			crc_last <= 16'h0;
			crc_any  <= 1'b0;
		end else if (rx_in_valid && next_mode == hciut_mode_h5) begin
			if (rx_sh == BYTE_SLIP) begin
				if (crc_any) begin
					crc_last <= crc_run;
				end
				crc_run <= CRC_INIT;
				crc_any <= 1'b0;
			end else begin
				crc_run <= crc_step(crc_run, rx_sh);
				crc_any <= 1'b1;
			end
		end
	end

	// Line idle: ten bit times of high line after the last byte
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			idle_arm  <= 1'b0;
			idle_cyc  <= 16'h0;
			idle_bits <= 4'h0;
		end else if (rx_got || rx_state != rx_idle || !rxd) begin
			idle_arm  <= idle_arm | rx_got;
			idle_cyc  <= 16'h0;
			idle_bits <= 4'h0;
		end else if (idle_bits == IDLE_BITS) begin
			idle_arm  <= 1'b0;
			idle_bits <= 4'h0;
		end else if (idle_arm) begin
			if (idle_cyc == baud_div - 16'h1) begin
				idle_cyc  <= 16'h0;
				idle_bits <= idle_bits + 4'h1;
			end else begin
				idle_cyc <= idle_cyc + 16'h1;
			end
		end
	end

	// Stop output: buffer near full or device asleep; unused in three-wire mode
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			host_flow_stop_out <= 1'b0;
			cts_q              <= 1'b0;
		end else begin
			cts_q              <= device_flow_stop_in;
			host_flow_stop_out <= asleep ||
				(mode != hciut_mode_h5 && rx_level >= rx_thresh);
		end
	end

endmodule

// ---- rtl/hciut_pkg.sv ----
// Constants and types for the host-interface UART transport
package hciut_pkg;

	localparam int unsigned CLK_HZ    = 40_000_000;
	localparam int unsigned BAUD_BOOT = 115_200;
	localparam int unsigned BAUD_MAX  = 4_000_000;
	localparam logic [15:0] DIV_BOOT  = 16'(CLK_HZ / BAUD_BOOT);
	localparam logic [15:0] DIV_MIN   = 16'(CLK_HZ / BAUD_MAX);

	localparam int unsigned FIFO_W     = 8;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam logic [3:0]  IDLE_BITS  = 4'ha;
	localparam logic [3:0]  THRESH_RST = 4'h6;

	// Register byte offsets
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_BAUD   = 12'h004;
	localparam logic [11:0] OFS_TXDATA = 12'h008;
	localparam logic [11:0] OFS_RXDATA = 12'h00c;
	localparam logic [11:0] OFS_STATUS = 12'h010;
	localparam logic [11:0] OFS_LEVEL  = 12'h014;
	localparam logic [11:0] OFS_THRESH = 12'h018;
	localparam logic [11:0] OFS_CRC    = 12'h01c;

	// Control fields, all reset to zero
	localparam int CTRL_PAR_EN  = 0;
	localparam int CTRL_PAR_ODD = 1;
	localparam int CTRL_PKT     = 2;
	localparam int CTRL_SLEEP   = 3;

	// Sticky status flags, bits 6:0 of STATUS
	localparam int ERR_BREAK = 0;
	localparam int ERR_IDLE  = 1;
	localparam int ERR_FRAME = 2;
	localparam int ERR_OVFL  = 3;
	localparam int ERR_PAR   = 4;
	localparam int ERR_UNDER = 5;
	localparam int ERR_WAKE  = 6;
	localparam int ERR_N     = 7;

	// Link bytes
	localparam logic [7:0] BYTE_SLIP = 8'hc0;
	localparam logic [7:0] BYTE_XON  = 8'h11;
	localparam logic [7:0] BYTE_XOFF = 8'h13;

	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;

	typedef enum logic [1:0] {hciut_mode_unknown, hciut_mode_h4, hciut_mode_h5} hciut_mode_t;
	typedef enum logic [2:0] {rx_idle, rx_start, rx_data, rx_par, rx_stop, rx_hold} hciut_rx_t;

endpackage

// ---- rtl/hciut_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module hciut_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         rstn,
	// Fill side
	input  wire logic                         in_valid,
	output logic                              in_ready,
	input  wire logic [WIDTH-1:0]             in_data,
	// Drain side
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic [WIDTH-1:0]                  out_data,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0]        level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = level != CW'(DEPTH);
	assign out_valid = level != '0;
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end

endmodule

// ---- dv/hciut_properties.sv ----
// Timing checks on the transport's register bus and serial pins
`timescale 1ns/1ps
module hciut_properties
	import hciut_pkg::*;
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        rstn,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Serial pins
	input wire logic        txd,
	input wire logic        device_flow_stop_in
);
	// Longer than an eleven-bit byte at the boot rate; slower rates are not covered
	localparam int STOP_SPAN = 3900;
	logic [11:0]   stop_cnt;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			stop_cnt <= 12'h000;
		else if (!device_flow_stop_in)
			stop_cnt <= 12'h000;
		else if (stop_cnt != 12'hfff)
			stop_cnt <= stop_cnt + 12'h001;
	end

	// A full-FIFO push may stall, so only other addresses get the fixed wait
	sequence apb_setup;
		psel && !penable && paddr != OFS_TXDATA;
	endsequence
	sequence apb_access;
		apb_setup ##1 psel && penable;
	endsequence

	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	one_wait_a: assert property (apb_access |=> pready)
		else $error("access not answered after one wait state");
	err_decode_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFS_CRC))
		else $error("error response does not match address map");
	err_data_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response with data or without ready");
	low_bit_hold_a: assert property ($fell(txd) |=> !txd [*8])
		else $error("low serial bit shorter than minimum bit time");
	high_bit_hold_a: assert property ($rose(txd) |=> txd [*8])
		else $error("high serial bit shorter than minimum bit time");
	stop_halts_a: assert property (stop_cnt >= 12'(STOP_SPAN) |-> !$fell(txd))
		else $error("byte started while flow stop held");
endmodule

// ---- dv/hciut_host_model.sv ----
// Host-side serial partner: sends frames on rxd, collects bytes from txd
`timescale 1ns/1ps
module hciut_host_model (
	// Clock and line rate in clocks per bit
	input wire logic        clock,
	input wire logic [15:0] div,
	// Serial pins
	output logic            rxd,
	input wire logic        txd,
	input wire logic        host_flow_stop_out,
	output logic            device_flow_stop_in,
	// Bench control of the stop line
	input wire logic        hold
);
	logic [7:0] got_q[$];
	logic       frame_bad;

	assign device_flow_stop_in = hold;

	initial begin
		rxd = 1'b1;
		frame_bad = 1'b0;
	end

	// Start bit, then n bits LSB first; waits for the stop request to clear first
	task automatic send(input logic [9:0] bits, input int n);
		while (host_flow_stop_out)
			@(posedge clock);
		rxd <= 1'b0;
		repeat (div) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			rxd <= bits[i];
			repeat (div) @(posedge clock);
		end
		rxd <= 1'b1;
		repeat (div) @(posedge clock);
	endtask

	// Samples mid-bit; a low stop bit is remembered for the bench
	always begin : rx_proc
		logic [8:0] f;
		@(negedge txd);
		repeat (div / 2) @(posedge clock);
		for (int i = 0; i < 9; i++) begin
			repeat (div) @(posedge clock);
			f[i] = txd;
		end
		if (!f[8])
			frame_bad = 1'b1;
		got_q.push_back(f[7:0]);
	end
endmodule

// ---- dv/test_hci_uart_transport.sv ----
// Self-checking bench for the host-interface UART transport
`timescale 1ns/1ps
module test_hci_uart_transport
	import hciut_pkg::*;
;
	logic        clock = 1'b0;
	logic        rstn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        rxd, txd, host_flow_stop_out, device_flow_stop_in, hold;
	logic [15:0] div;
	int          bad_count = 0;
	int          compares = 0;

	always #12.5 clock = ~clock;

	hciut_top dut_u (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.host_flow_stop_out(host_flow_stop_out), .device_flow_stop_in(device_flow_stop_in));
	hciut_host_model host_u (.clock(clock), .div(div), .rxd(rxd), .txd(txd),
		.host_flow_stop_out(host_flow_stop_out),
		.device_flow_stop_in(device_flow_stop_in), .hold(hold));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// Only the watchdog ends a stalled access
		while (!pready)
			@(posedge clock);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next setup never lands in this time step
		@(posedge clock);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask

	task automatic wait_got(input int n);
		while (host_u.got_q.size() < n)
			@(posedge clock);
	endtask

	task automatic got_is(input logic [7:0] b);
		check({24'h0, host_u.got_q.pop_front()}, {24'h0, b});
	endtask

	// Character frame: data, then the stop level
	function automatic logic [9:0] frm(input logic [7:0] d, input logic s);
		return {1'b0, s, d};
	endfunction

	function automatic logic [15:0] crc16(input logic [7:0] d[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (d[i]) begin
			c = c ^ {8'h00, d[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  b, b2;
		logic [7:0]  q[$];
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		hold = 1'b0;
		div = DIV_BOOT;
		void'($urandom(12));
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		rd(OFS_BAUD, r);
		check(r, {16'h0, DIV_BOOT});
		rd(OFS_THRESH, r);
		check(r, {28'h0, THRESH_RST});
		rd(OFS_STATUS, r);
		check(r, 32'h0);
		rd(OFS_CTRL, r);
		check(r, 32'h0);
		apb(1'b0, 12'h020, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		// Two bytes at the boot rate, then a rate change that must wait for them
		b = 8'($urandom);
		b2 = 8'($urandom);
		wr(OFS_TXDATA, {24'h0, b});
		wr(OFS_TXDATA, {24'h0, b2});
		wr(OFS_BAUD, 32'h10);
		rd(OFS_STATUS, r);
		check({31'h0, r[11]}, 32'h1);
		wait_got(2);
		got_is(b);
		got_is(b2);
		repeat (400) @(posedge clock);
		div <= 16'h0010;
		rd(OFS_BAUD, r);
		check(r, 32'h10);
		wr(OFS_BAUD, 32'h5);
		rd(OFS_BAUD, r);
		check(r, {16'h0, DIV_MIN});
		wr(OFS_BAUD, 32'h10);
		// First bytes from the host pick four-wire framing
		for (int i = 0; i < 4; i++) begin
			q.push_back(8'($urandom_range(32, 127)));
			host_u.send(frm(q[i], 1'b1), 9);
		end
		rd(OFS_STATUS, r);
		check({30'h0, r[9:8]}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			rd(OFS_RXDATA, r);
			check(r, {24'h0, q[i]});
		end
		for (int i = 0; i < 6; i++)
			host_u.send(frm(8'($urandom), 1'b1), 9);
		repeat (4) @(posedge clock);
		check({31'h0, host_flow_stop_out}, 32'h1);
		rd(OFS_LEVEL, r);
		check({28'h0, r[3:0]}, 32'h6);
		rd(OFS_RXDATA, r);
		repeat (4) @(posedge clock);
		check({31'h0, host_flow_stop_out}, 32'h0);
		for (int i = 0; i < 5; i++)
			rd(OFS_RXDATA, r);
		// Overflow, idle, break, framing and parity flags
		wr(OFS_THRESH, 32'hf);
		for (int i = 0; i < 9; i++)
			host_u.send(frm(8'($urandom), 1'b1), 9);
		rd(OFS_LEVEL, r);
		check({28'h0, r[3:0]}, 32'h8);
		repeat (200) @(posedge clock);
		rd(OFS_STATUS, r);
		check({30'h0, r[3], r[1]}, 32'h3);
		wr(OFS_STATUS, 32'h7f);
		rd(OFS_STATUS, r);
		check({25'h0, r[6:0]}, 32'h0);
		for (int i = 0; i < 8; i++)
			rd(OFS_RXDATA, r);
		host_u.send(frm(8'h00, 1'b0), 9);
		rd(OFS_STATUS, r);
		check({31'h0, r[0]}, 32'h1);
		host_u.send(frm(8'h5a, 1'b0), 9);
		rd(OFS_STATUS, r);
		check({31'h0, r[2]}, 32'h1);
		wr(OFS_CTRL, 32'h1);
		b = 8'($urandom);
		host_u.send({1'b1, ~(^b), b}, 10);
		rd(OFS_STATUS, r);
		check({31'h0, r[4]}, 32'h1);
		// Odd parity: a good frame leaves the flag clear, a bad one sets it
		wr(OFS_STATUS, 32'h10);
		wr(OFS_CTRL, 32'h3);
		host_u.send({1'b1, ~(^b), b}, 10);
		rd(OFS_STATUS, r);
		check({31'h0, r[4]}, 32'h0);
		host_u.send({1'b1, ^b, b}, 10);
		rd(OFS_STATUS, r);
		check({31'h0, r[4]}, 32'h1);
		wr(OFS_CTRL, 32'h0);
		// Stop asserted mid-byte: that byte completes, the next waits
		b = 8'($urandom);
		b2 = 8'($urandom);
		wr(OFS_TXDATA, {24'h0, b});
		wr(OFS_TXDATA, {24'h0, b2});
		while (txd)
			@(posedge clock);
		hold <= 1'b1;
		repeat (4000) @(posedge clock);
		check(host_u.got_q.size(), 32'h1);
		rd(OFS_LEVEL, r);
		check({28'h0, r[11:8]}, 32'h1);
		hold <= 1'b0;
		wait_got(2);
		got_is(b);
		got_is(b2);
		check({31'h0, host_u.frame_bad}, 32'h0);
		wr(OFS_CTRL, 32'h4);
		wr(OFS_TXDATA, {24'h0, b});
		wait_got(1);
		got_is(b);
		repeat (20) @(posedge clock);
		rd(OFS_STATUS, r);
		check({31'h0, r[5]}, 32'h1);
		wr(OFS_CTRL, 32'h8);
		repeat (5) @(posedge clock);
		check({31'h0, host_flow_stop_out}, 32'h1);
		hold <= 1'b1;
		@(posedge clock);
		hold <= 1'b0;
		repeat (3) @(posedge clock);
		rd(OFS_STATUS, r);
		check({30'h0, r[12], r[6]}, 32'h3);
		wr(OFS_CTRL, 32'h0);
		// Second reset, then three-wire framing with checksum and pause bytes
		rstn <= 1'b0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		wr(OFS_BAUD, 32'h10);
		q.delete();
		for (int i = 0; i < 3; i++)
			q.push_back(8'($urandom_range(32, 127)));
		host_u.send(frm(BYTE_SLIP, 1'b1), 9);
		foreach (q[i])
			host_u.send(frm(q[i], 1'b1), 9);
		host_u.send(frm(BYTE_SLIP, 1'b1), 9);
		rd(OFS_STATUS, r);
		check({30'h0, r[9:8]}, 32'h2);
		rd(OFS_CRC, r);
		check(r, {16'h0, crc16(q)});
		host_u.send(frm(BYTE_XOFF, 1'b1), 9);
		rd(OFS_STATUS, r);
		check({31'h0, r[10]}, 32'h1);
		wr(OFS_TXDATA, {24'h0, b2});
		repeat (400) @(posedge clock);
		check(host_u.got_q.size(), 32'h0);
		host_u.send(frm(BYTE_XON, 1'b1), 9);
		wait_got(1);
		got_is(b2);
		give_verdict();
	end

	initial begin
		repeat (60000) @(posedge clock);
		bad_count++;
		give_verdict();
	end
endmodule

bind hciut_top hciut_properties chk_u (.clock(clock), .rstn(rstn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .txd(txd), .device_flow_stop_in(device_flow_stop_in));
